// ===== inc/gpio_port_pkg.sv
// Package with register map, field positions and reset values of the port.
package gpio_port_pkg;

   // ==========================================================================
   // Widths
   // ==========================================================================
   localparam int PORT_WIDTH = 8;
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 8;

   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [3:0] OFS_DATA_LATCH    = 4'h0;
   localparam logic [3:0] OFS_DIRECTION     = 4'h1;
   localparam logic [3:0] OFS_PULL_ENABLE   = 4'h2;
   localparam logic [3:0] OFS_SLEW_ENABLE   = 4'h3;
   localparam logic [3:0] OFS_DRIVE_SELECT  = 4'h4;
   localparam logic [3:0] OFS_IRQ_STAT_CTRL = 4'h5;
   localparam logic [3:0] OFS_IRQ_PIN_SEL   = 4'h6;
   localparam logic [3:0] OFS_EDGE_POL_SEL  = 4'h7;

   // ==========================================================================
   // Status/control field positions
   // ==========================================================================
   localparam int SC_FLAG_BIT = 3;
   localparam int SC_ACK_BIT  = 2;
   localparam int SC_IE_BIT   = 1;
   localparam int SC_MODE_BIT = 0;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic       RST_BIT  = 1'b0;

endpackage : gpio_port_pkg

// ===== inc/irq_detect_if.sv
// Interface carrying pin samples and configuration to the interrupt detector.
`timescale 1ns/1ps
interface irq_detect_if #(parameter int W = 8);
   logic [W-1:0] pin_level;
   logic [W-1:0] pin_select;
   logic [W-1:0] edge_polarity;
   logic         detect_mode;
   logic         ack_write;
   logic         flag;
   logic         all_deasserted;

   modport ctrl (output pin_level, output pin_select, output edge_polarity,
                 output detect_mode, output ack_write,
                 input flag, input all_deasserted);
   modport det  (input pin_level, input pin_select, input edge_polarity,
                 input detect_mode, input ack_write,
                 output flag, output all_deasserted);
endinterface : irq_detect_if

// ===== src/port_irq_detect.sv
// Interrupt detector: synchronous edge/level detection and the sticky flag.
`timescale 1ns/1ps
module port_irq_detect #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic  i_ref_clk,
   input  wire logic  i_rst_b,
   // Detector carrier
   irq_detect_if.det  bus
);
   import gpio_port_pkg::*;

   // ==========================================================================
   // State
   // ==========================================================================
   logic [W-1:0] asserted;
   logic [W-1:0] prev_asserted_ff;
   logic [W-1:0] nxt_prev_asserted;
   logic         flag_ff;
   logic         nxt_flag;
   logic         event_now;

   // A pin counts as asserted at high level when its polarity bit is 1.
   // Unselected pins read as deasserted so they never contribute.
   always_comb begin
      asserted = ~(bus.pin_level ^ bus.edge_polarity) // RULE13
                 & bus.pin_select; // RULE12
      nxt_prev_asserted = asserted;
      // An edge is deasserted in one cycle and asserted in the next.
      event_now = |(asserted & ~prev_asserted_ff); // RULE15
      if (bus.detect_mode) begin
         event_now = event_now | (|asserted); // RULE11
      end
      nxt_flag = flag_ff;
      if (bus.ack_write && (!bus.detect_mode || !(|asserted))) begin
         nxt_flag = RST_BIT; // RULE14
      end
      // Detection wins over a clear in the same cycle.
      if (event_now) begin
         nxt_flag = 1'b1; // RULE17
      end
   end

   // Register stage. Previous samples reset to deasserted, so a pin already
   // asserted when selected gives one false edge; software acks it.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_asserted_ff <= '0;
         flag_ff          <= RST_BIT;
      end else begin
         prev_asserted_ff <= nxt_prev_asserted;
         flag_ff          <= nxt_flag;
      end
   end

   assign bus.flag           = flag_ff;
   assign bus.all_deasserted = ~(|asserted);

   // ==========================================================================
   // Assertions
   // ==========================================================================
   AST_EDGE_SETS_FLAG: assert property ( // RULE15
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (|(asserted & ~prev_asserted_ff)) |=> flag_ff)
      else $error("Edge did not set the flag.");

   AST_LEVEL_HOLDS_FLAG: assert property ( // RULE14
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (bus.detect_mode && (|asserted) && flag_ff) |=> flag_ff)
      else $error("Flag cleared while a level was asserted.");

   AST_ACK_CLEARS: assert property ( // RULE14
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (bus.ack_write && !event_now) |=> !flag_ff)
      else $error("Acknowledge failed to clear the flag.");

   AST_NO_SPURIOUS_SET: assert property ( // RULE12
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (!flag_ff && !event_now) |=> !flag_ff)
      else $error("Flag set without a detected event.");

   AST_EDGE_ONLY_IGNORES_LEVEL: assert property ( // RULE11
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (!bus.detect_mode && !flag_ff && (asserted == prev_asserted_ff))
      |=> !flag_ff)
      else $error("Edge mode reacted to a steady level.");

endmodule : port_irq_detect

// ===== src/gpio_port.sv
// Eight-pin general-purpose port with pin control and port interrupt.
// ============================================================================
// What this block does
// [RULE1] Direction 0 disables the driver; data reads return the pin level.
// [RULE2] Direction 1 enables the driver; data reads return the latch bit.
// [RULE3] Pull-enable 1 turns on the pin's pull device, but not on outputs.
// [RULE4] The pull is a pull-down only on interrupt pins of rising polarity.
// [RULE5] Each slew bit enables slew control on its pin; no effect on inputs.
// [RULE6] Software always writes the slew setting rather than trust reset.
// [RULE7] Drive bit 0 picks low and 1 high drive; no effect on inputs.
// [RULE8] Status bit 3 is the interrupt flag, set by detection, not writes.
// [RULE9] Status bit 2 is a write-1 acknowledge that always reads 0.
// [RULE10] Status bit 1 gates the interrupt request onto the request output.
// [RULE11] Status bit 0 picks edge-only detection at 0, edge-and-level at 1.
// [RULE12] Only pins whose pin-select bit is 1 take part in the interrupt.
// [RULE13] Polarity 0 sets pull-up and low sense, 1 pull-down and high sense.
// [RULE14] With levels on, ack clears the flag only when no pin is asserted.
// [RULE15] An edge is a deasserted sample and an asserted one a cycle later.
// [RULE16] Writes latch all data bits; reset clears them but drives no pin.
// [RULE17] A detection in the acknowledge cycle keeps the flag set.
// ============================================================================
`timescale 1ns/1ps
module gpio_port #(
   parameter int PINS = gpio_port_pkg::PORT_WIDTH
) (
   // Clock and reset
   input  wire logic                                i_ref_clk,
   input  wire logic                                i_rst_b,
   // Register port
   input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0] i_addr,
   input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] i_wdata,
   input  wire logic                                i_wr,
   input  wire logic                                i_rd,
   output logic      [gpio_port_pkg::DATA_WIDTH-1:0] o_rdata,
   // Pins
   input  wire logic [PINS-1:0]                     i_pin,
   output logic      [PINS-1:0]                     o_pin,
   output logic      [PINS-1:0]                     o_pin_oe_b,
   // Pad controls
   output logic      [PINS-1:0]                     o_pull_en,
   output logic      [PINS-1:0]                     o_pull_down,
   output logic      [PINS-1:0]                     o_slew_en,
   output logic      [PINS-1:0]                     o_drive_high,
   // Interrupt request
   output logic                                     o_irq_req
);
   import gpio_port_pkg::*;

   // A register byte carries one bit per pin, so the widths must agree.
   if (PINS != DATA_WIDTH) begin : g_width_check
      $error("PINS must equal the register data width.");
   end

   // ==========================================================================
   // Reset synchroniser
   // ==========================================================================
   logic rst_sync1_ff;
   logic rst_sync2_ff;
   logic rst_b;

   // Release is delayed two edges so all flops leave reset together.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_sync1_ff <= 1'b0;
         rst_sync2_ff <= 1'b0;
      end else begin
         rst_sync1_ff <= 1'b1;
         rst_sync2_ff <= rst_sync1_ff;
      end
   end
   assign rst_b = rst_sync2_ff;

   // ==========================================================================
   // Register file
   // ==========================================================================
   logic [PINS-1:0] data_latch_ff,    nxt_data_latch;
   logic [PINS-1:0] direction_ff,     nxt_direction;
   logic [PINS-1:0] pull_enable_ff,   nxt_pull_enable;
   logic [PINS-1:0] slew_enable_ff,   nxt_slew_enable;
   logic [PINS-1:0] drive_select_ff,  nxt_drive_select;
   logic [PINS-1:0] pin_select_ff,    nxt_pin_select;
   logic [PINS-1:0] edge_polarity_ff, nxt_edge_polarity;
   logic            irq_enable_ff,    nxt_irq_enable;
   logic            detect_mode_ff,   nxt_detect_mode;
   logic [DATA_WIDTH-1:0] rdata_ff,   nxt_rdata;
   logic [DATA_WIDTH-1:0] sc_view;
   logic            ack_write;

   irq_detect_if #(.W(PINS)) det_if ();

   // Write decode is reused by every register, so it lives in a function.
   function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   // Next values of all software-written registers.
   always_comb begin
      nxt_data_latch    = data_latch_ff;
      nxt_direction     = direction_ff;
      nxt_pull_enable   = pull_enable_ff;
      nxt_slew_enable   = slew_enable_ff;
      nxt_drive_select  = drive_select_ff;
      nxt_pin_select    = pin_select_ff;
      nxt_edge_polarity = edge_polarity_ff;
      nxt_irq_enable    = irq_enable_ff;
      nxt_detect_mode   = detect_mode_ff;
      if (i_wr) begin
         if (hit(i_addr, OFS_DATA_LATCH)) begin
            nxt_data_latch = i_wdata; // RULE16
         end
         if (hit(i_addr, OFS_DIRECTION)) begin
            nxt_direction = i_wdata;
         end
         if (hit(i_addr, OFS_PULL_ENABLE)) begin
            nxt_pull_enable = i_wdata;
         end
         if (hit(i_addr, OFS_SLEW_ENABLE)) begin
            nxt_slew_enable = i_wdata;
         end
         if (hit(i_addr, OFS_DRIVE_SELECT)) begin
            nxt_drive_select = i_wdata;
         end
         if (hit(i_addr, OFS_IRQ_PIN_SEL)) begin
            nxt_pin_select = i_wdata;
         end
         if (hit(i_addr, OFS_EDGE_POL_SEL)) begin
            nxt_edge_polarity = i_wdata;
         end
         // The flag bit is not writable; only enable and mode are stored.
         if (hit(i_addr, OFS_IRQ_STAT_CTRL)) begin
            nxt_irq_enable  = i_wdata[SC_IE_BIT];
            nxt_detect_mode = i_wdata[SC_MODE_BIT]; // RULE8
         end
      end
   end

   assign ack_write = i_wr && hit(i_addr, OFS_IRQ_STAT_CTRL)
                      && i_wdata[SC_ACK_BIT]; // RULE9

   // Status view: the acknowledge bit is never stored, so it reads as zero.
   always_comb begin
      sc_view              = '0;
      sc_view[SC_FLAG_BIT] = det_if.flag; // RULE8
      sc_view[SC_ACK_BIT]  = 1'b0; // RULE9
      sc_view[SC_IE_BIT]   = irq_enable_ff;
      sc_view[SC_MODE_BIT] = detect_mode_ff;
   end

   // Read mux; data reads mix pin levels and latch by direction.
   always_comb begin
      nxt_rdata = '0;
      if (i_rd) begin
         case (i_addr)
            OFS_DATA_LATCH:    nxt_rdata = (direction_ff & data_latch_ff) |
               (~direction_ff & i_pin); // RULE1 RULE2
            OFS_DIRECTION:     nxt_rdata = direction_ff;
            OFS_PULL_ENABLE:   nxt_rdata = pull_enable_ff;
            OFS_SLEW_ENABLE:   nxt_rdata = slew_enable_ff;
            OFS_DRIVE_SELECT:  nxt_rdata = drive_select_ff;
            OFS_IRQ_STAT_CTRL: nxt_rdata = sc_view;
            OFS_IRQ_PIN_SEL:   nxt_rdata = pin_select_ff;
            OFS_EDGE_POL_SEL:  nxt_rdata = edge_polarity_ff;
            default:           nxt_rdata = '0;
         endcase
      end
   end

   // Register stage; reset makes every pin an input with pulls off.
   always_ff @(posedge i_ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_latch_ff    <= RST_BYTE; // RULE16
         direction_ff     <= RST_BYTE;
         pull_enable_ff   <= RST_BYTE;
         slew_enable_ff   <= RST_BYTE;
         drive_select_ff  <= RST_BYTE;
         pin_select_ff    <= RST_BYTE;
         edge_polarity_ff <= RST_BYTE;
         irq_enable_ff    <= RST_BIT;
         detect_mode_ff   <= RST_BIT;
         rdata_ff         <= RST_BYTE;
      end else begin
         data_latch_ff    <= nxt_data_latch;
         direction_ff     <= nxt_direction;
         pull_enable_ff   <= nxt_pull_enable;
         slew_enable_ff   <= nxt_slew_enable;
         drive_select_ff  <= nxt_drive_select;
         pin_select_ff    <= nxt_pin_select;
         edge_polarity_ff <= nxt_edge_polarity;
         irq_enable_ff    <= nxt_irq_enable;
         detect_mode_ff   <= nxt_detect_mode;
         rdata_ff         <= nxt_rdata;
      end
   end

   assign o_rdata = rdata_ff;

   // ==========================================================================
   // Pin and pad control
   // ==========================================================================
   // Pad controls are masked per pin so an input never sees output settings.
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         assign o_pin[g]      = data_latch_ff[g];
         assign o_pin_oe_b[g] = ~direction_ff[g]; // RULE1 RULE2
         assign o_pull_en[g]  = pull_enable_ff[g] & ~direction_ff[g]; // RULE3
         assign o_pull_down[g] = pull_enable_ff[g] & ~direction_ff[g]
                                 & pin_select_ff[g]
                                 & edge_polarity_ff[g]; // RULE4 RULE13
         assign o_slew_en[g]    = slew_enable_ff[g] & direction_ff[g]; // RULE5
         assign o_drive_high[g] = drive_select_ff[g]
                                  & direction_ff[g]; // RULE7
      end
   endgenerate

   // ==========================================================================
   // Interrupt detection
   // ==========================================================================
   // Pins are synchronous by contract, so they feed the detector directly.
   assign det_if.pin_level     = i_pin;
   assign det_if.pin_select    = pin_select_ff;
   assign det_if.edge_polarity = edge_polarity_ff;
   assign det_if.detect_mode   = detect_mode_ff;
   assign det_if.ack_write     = ack_write;

   port_irq_detect #(.W(PINS)) u_det (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (rst_b),
      .bus       (det_if.det)
   );

   assign o_irq_req = det_if.flag & irq_enable_ff; // RULE10

   // ==========================================================================
   // Assertions
   // ==========================================================================
   sequence s_sc_write_ack;
      i_wr && (i_addr == OFS_IRQ_STAT_CTRL) && i_wdata[SC_ACK_BIT];
   endsequence

   AST_OUT_DISABLED_FOR_INPUT: assert property ( // RULE1
      @(posedge i_ref_clk) disable iff (!rst_b)
      (o_pin_oe_b == ~direction_ff) && ((o_pull_en & direction_ff) == '0))
      else $error("Driver or pull active on the wrong pins.");

   AST_DATA_READBACK: assert property ( // RULE2
      @(posedge i_ref_clk) disable iff (!rst_b)
      (i_rd && (i_addr == OFS_DATA_LATCH)) |=>
      (o_rdata == (($past(direction_ff) & $past(data_latch_ff)) |
                   (~$past(direction_ff) & $past(i_pin)))))
      else $error("Data read returned the wrong source.");

   AST_ACK_READS_ZERO: assert property ( // RULE9
      @(posedge i_ref_clk) disable iff (!rst_b)
      (i_rd && (i_addr == OFS_IRQ_STAT_CTRL)) |=> !o_rdata[SC_ACK_BIT])
      else $error("Acknowledge bit read back as one.");

   AST_ACK_CLEARS_EDGE_MODE: assert property ( // RULE14
      @(posedge i_ref_clk) disable iff (!rst_b)
      (s_sc_write_ack ##0 (!detect_mode_ff && !u_det.event_now))
      |=> !det_if.flag)
      else $error("Edge-mode acknowledge did not clear the flag.");

   AST_IRQ_GATE: assert property ( // RULE10
      @(posedge i_ref_clk) disable iff (!rst_b)
      o_irq_req == (det_if.flag && irq_enable_ff))
      else $error("Interrupt request not gated by the enable.");

   AST_PAD_MASKS: assert property ( // RULE5
      @(posedge i_ref_clk) disable iff (!rst_b)
      ((o_slew_en | o_drive_high) & ~direction_ff) == '0)
      else $error("Slew or drive active on an input pin.");

   AST_DATA_WRITE: assert property ( // RULE16
      @(posedge i_ref_clk) disable iff (!rst_b)
      (i_wr && (i_addr == OFS_DATA_LATCH)) |=> o_pin == $past(i_wdata))
      else $error("Data write not latched.");

   // Writes that do not acknowledge must leave a clear flag clear.
   sequence s_sc_write_quiet;
      i_wr && (i_addr == OFS_IRQ_STAT_CTRL) && !i_wdata[SC_ACK_BIT];
   endsequence

   AST_FLAG_WRITE_IGNORED: assert property ( // RULE8
      @(posedge i_ref_clk) disable iff (!rst_b)
      (s_sc_write_quiet ##0 (!det_if.flag && !u_det.event_now))
      |=> !det_if.flag)
      else $error("Status write changed the flag.");

   AST_DIR_WRITE: assert property ( // RULE1
      @(posedge i_ref_clk) disable iff (!rst_b)
      (i_wr && (i_addr == OFS_DIRECTION)) |=> o_pin_oe_b == ~$past(i_wdata))
      else $error("Direction write did not reach the drivers.");

   // A pull-down without a selected rising interrupt pin would fight the
   // pin's idle level, so it is checked on every cycle.
   AST_PULL_DOWN_IRQ_ONLY: assert property ( // RULE4
      @(posedge i_ref_clk) disable iff (!rst_b)
      (o_pull_down & ~(o_pull_en & pin_select_ff & edge_polarity_ff)) == '0)
      else $error("Pull-down enabled outside an interrupt pin.");

   // In level mode a held level must raise the flag on the next edge.
   AST_LEVEL_SETS_FLAG: assert property ( // RULE11
      @(posedge i_ref_clk) disable iff (!rst_b)
      (detect_mode_ff && !det_if.all_deasserted) |=> det_if.flag)
      else $error("Asserted level did not set the flag in level mode.");

endmodule : gpio_port

// ===== dv/testbench.sv
// Self-checking testbench for the eight-pin port and its interrupt logic.
`timescale 1ns/1ps
module testbench;
   import gpio_port_pkg::*;

   // ==========================================================================
   // Signals
   // ==========================================================================
   logic                  i_ref_clk;
   logic                  i_rst_b;
   logic [ADDR_WIDTH-1:0] i_addr;
   logic [DATA_WIDTH-1:0] i_wdata;
   logic                  i_wr;
   logic                  i_rd;
   logic [DATA_WIDTH-1:0] o_rdata;
   logic [PORT_WIDTH-1:0] i_pin;
   logic [PORT_WIDTH-1:0] o_pin;
   logic [PORT_WIDTH-1:0] o_pin_oe_b;
   logic [PORT_WIDTH-1:0] o_pull_en;
   logic [PORT_WIDTH-1:0] o_pull_down;
   logic [PORT_WIDTH-1:0] o_slew_en;
   logic [PORT_WIDTH-1:0] o_drive_high;
   logic                  o_irq_req;
   int                    error_cnt;
   int                    check_count;

   gpio_port #(.PINS(PORT_WIDTH)) dut (
      .i_ref_clk    (i_ref_clk),
      .i_rst_b      (i_rst_b),
      .i_addr       (i_addr),
      .i_wdata      (i_wdata),
      .i_wr         (i_wr),
      .i_rd         (i_rd),
      .o_rdata      (o_rdata),
      .i_pin        (i_pin),
      .o_pin        (o_pin),
      .o_pin_oe_b   (o_pin_oe_b),
      .o_pull_en    (o_pull_en),
      .o_pull_down  (o_pull_down),
      .o_slew_en    (o_slew_en),
      .o_drive_high (o_drive_high),
      .o_irq_req    (o_irq_req)
   );

   // ==========================================================================
   // Clock, 100 MHz.
   // ==========================================================================
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   // ==========================================================================
   // Bus and compare tasks
   // ==========================================================================
   // Each bus task starts on a fresh edge, so no strobe is assigned twice at once.
   task automatic wrp(input logic [3:0] a, input logic [7:0] d,
                      input logic [7:0] p);
      @(posedge i_ref_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      i_pin   <= p;
      @(posedge i_ref_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      wrp(a, d, i_pin);
   endtask

   task automatic set_pin(input logic [7:0] p);
      @(posedge i_ref_clk);
      i_pin <= p;
      repeat (3) @(posedge i_ref_clk);
   endtask

   task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Read data stand only in the cycle after the strobe, so sample it there.
   task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_ref_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd   <= 1'b0;
      #1 chk_out(o_rdata, exp);
   endtask

   task automatic test_done();
      $display("checks=%0d mismatches=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================================
   // Watchdog: the whole sequence needs well under a thousand cycles.
   // ==========================================================================
   initial begin
      repeat (5000) @(posedge i_ref_clk);
      error_cnt++;
      test_done();
   end

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      error_cnt   = 0;
      check_count = 0;
      i_rst_b     = 1'b0;
      i_addr      = 4'h0;
      i_wdata     = 8'h00;
      i_wr        = 1'b0;
      i_rd        = 1'b0;
      i_pin       = 8'h5A;
      repeat (20) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      // Reset state: all pins inputs, pad controls off, registers clear.
      #1 chk_out(o_pin_oe_b, 8'hFF);
      chk_out(o_pin, 8'h00);
      chk_out({o_pull_en | o_slew_en | o_drive_high}, 8'h00);
      for (int a = 1; a < 8; a++) chk_reg(a[3:0], 8'h00);
      chk_reg(OFS_DATA_LATCH, 8'h5A);
      // Unmapped offsets read zero and swallow writes.
      wr(4'h8, 8'hFF);
      wr(4'hF, 8'hFF);
      chk_reg(4'h8, 8'h00);
      chk_reg(4'hF, 8'h00);
      $display("test reset done");

      // Direction, data and pad controls.
      wr(OFS_DATA_LATCH, 8'hA5);
      #1 chk_out(o_pin_oe_b, 8'hFF);
      chk_out(o_pin, 8'hA5);
      wr(OFS_DIRECTION, 8'h0F);
      #1 chk_out(o_pin_oe_b, 8'hF0);
      chk_reg(OFS_DATA_LATCH, 8'h55);
      wr(OFS_PULL_ENABLE, 8'hFF);
      wr(OFS_SLEW_ENABLE, 8'hFF);
      wr(OFS_DRIVE_SELECT, 8'h3C);
      wr(OFS_IRQ_PIN_SEL, 8'hF0);
      wr(OFS_EDGE_POL_SEL, 8'h30);
      #1 chk_out(o_pull_en, 8'hF0);
      chk_out(o_slew_en, 8'h0F);
      chk_out(o_drive_high, 8'h0C);
      chk_out(o_pull_down, 8'h30);
      chk_reg(OFS_SLEW_ENABLE, 8'hFF);
      chk_reg(OFS_DRIVE_SELECT, 8'h3C);
      chk_reg(OFS_EDGE_POL_SEL, 8'h30);
      wr(OFS_DIRECTION, 8'h00);
      #1 chk_out(o_slew_en | o_drive_high, 8'h00);
      chk_out(o_pull_en, 8'hFF);
      wr(OFS_PULL_ENABLE, 8'h00);
      wr(OFS_IRQ_PIN_SEL, 8'h00);
      $display("test pins done");

      // Edge-only detection on pin 0, falling polarity.
      set_pin(8'hFF);
      wr(OFS_EDGE_POL_SEL, 8'h00);
      wr(OFS_IRQ_PIN_SEL, 8'h01);
      wr(OFS_IRQ_STAT_CTRL, 8'h06);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h02);
      set_pin(8'hFD);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h02);
      set_pin(8'hFC);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h0A);
      #1 chk_out(o_irq_req, 1'b1);
      wr(OFS_IRQ_STAT_CTRL, 8'h02);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h0A);
      wr(OFS_IRQ_STAT_CTRL, 8'h00);
      #1 chk_out(o_irq_req, 1'b0);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h08);
      wr(OFS_IRQ_STAT_CTRL, 8'h04);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h00);
      // A write of one to the flag bit alone must not set it.
      wr(OFS_IRQ_STAT_CTRL, 8'h08);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h00);
      $display("test edge done");

      // Edge-and-level mode: a held level refuses the acknowledge.
      wr(OFS_IRQ_STAT_CTRL, 8'h01);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h09);
      wr(OFS_IRQ_STAT_CTRL, 8'h05);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h09);
      set_pin(8'hFF);
      wr(OFS_IRQ_STAT_CTRL, 8'h05);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h01);
      $display("test level done");

      // Rising polarity, then an edge landing on the acknowledge cycle.
      wr(OFS_IRQ_STAT_CTRL, 8'h00);
      set_pin(8'hFE);
      wr(OFS_EDGE_POL_SEL, 8'h01);
      wr(OFS_IRQ_STAT_CTRL, 8'h04);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h00);
      set_pin(8'hFF);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h08);
      set_pin(8'hFE);
      wr(OFS_IRQ_STAT_CTRL, 8'h04);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h00);
      wrp(OFS_IRQ_STAT_CTRL, 8'h04, 8'hFF);
      repeat (2) @(posedge i_ref_clk);
      chk_reg(OFS_IRQ_STAT_CTRL, 8'h08);
      $display("test polarity done");
      test_done();
   end
endmodule // testbench
